// [core/status_lamp_encoder.v]
// Decided for this implementation: register access over AHB-Lite and the address map.
`timescale 1ns/1ps
`default_nettype none
`include "lamp_consts.vh"

// Behaviour
// RULE1: healthy idle radio shows power/transmit lamp steady green.
// RULE2: transmitter active turns power/transmit lamp red, green again after.
// RULE3: fault enters error state: all lamps red, then green fault pattern.
// RULE4: supply fault pattern lights only power/transmit lamp green.
// RULE5: receive oscillator fault lights port A and receive/sync green.
// RULE6: transmit oscillator fault lights port A and power/transmit green.
// RULE7: other green patterns only for serious hardware faults.
// RULE8: no incoming signal turns the receive/sync lamp off.
// RULE9: carrier without decoded data shows receive/sync lamp red.
// RULE10: locked and synchronised receiver shows receive/sync lamp steady green.
// RULE11: sync loss or bit error pulses receive/sync lamp red briefly.
// RULE12: port input data flashes that port's lamp red.
// RULE13: port output data flashes that port's lamp green; alternation looks orange. Here red wins while both flashes overlap, so no orange shows.
// RULE14: flash and error display times are clock-cycle parameters.
// RULE15: error state persists, repeating its display, until reset.
module status_lamp_encoder #(
    parameter FLASH_CYCLES   = `FLASH_CYCLES,
    parameter FLICKER_CYCLES = `FLICKER_CYCLES,
    parameter PHASE_CYCLES   = `PHASE_CYCLES
) (
    // clock and reset
    input  wire        ref_clk,
    input  wire        rst,
    // radio conditions
    input  wire        tx_active,
    input  wire        carrier_detect,
    input  wire        sync_locked,
    input  wire        sync_error,
    input  wire        port_a_in,
    input  wire        port_a_out,
    input  wire        port_b_in,
    input  wire        port_b_out,
    input  wire        supply_fault,
    input  wire        receive_oscillator_lock,
    input  wire        transmit_oscillator_lock,
    input  wire        hardware_fault,
    // lamps, {red, green}
    output reg  [1:0]  power_lamp,
    output reg  [1:0]  sync_lamp,
    output reg  [1:0]  port_a_lamp,
    output reg  [1:0]  port_b_lamp,
    // ahb-lite slave
    input  wire        hsel,
    input  wire [31:0] haddr,
    input  wire [1:0]  htrans,
    input  wire        hwrite,
    input  wire [2:0]  hsize,
    input  wire [31:0] hwdata,
    input  wire        hready,
    output reg  [31:0] hrdata,
    output reg         hreadyout,
    output reg         hresp,
    // interrupt
    output reg         irq
);

    localparam ST_NORMAL = 2'd0;
    localparam ST_RED    = 2'd1;
    localparam ST_GREEN  = 2'd2;

    reg [1:0]  state;
    reg [1:0]  next_state;
    reg [1:0]  fault_code;
    reg [31:0] phase_cnt;
    reg [31:0] flicker_cnt;
    wire [3:0] flash_req;
    wire [3:0] flash_on;
    wire [3:0] pattern;
    wire [`EV_COUNT-1:0] ev_set;
    wire [`EV_COUNT-1:0] ev_clr;
    wire       wr_mask;
    wire       wr_control;
    wire       wr_status;
    reg [`EV_COUNT-1:0] status;
    reg [`EV_COUNT-1:0] mask;
    reg        lamp_test;
    reg        tx_prev;
    reg        wr_pend;
    reg        rd_pend;
    reg [7:0]  addr_q;
    wire       in_error;
    wire [1:0] new_code;
    wire       any_fault;
    wire       addr_ok;

    // green pattern per fault as {port a, port b, sync, power}
    function [3:0] fault_pattern;
        input [1:0] code;
        begin
            case (code)
                `FAULT_SUPPLY: fault_pattern = 4'b0001; // RULE4
                `FAULT_RX_OSC: fault_pattern = 4'b1010; // RULE5
                `FAULT_TX_OSC: fault_pattern = 4'b1001; // RULE6
                default:       fault_pattern = 4'b1111; // RULE7
            endcase
        end
    endfunction

    function [1:0] green_if;
        input on;
        begin
            green_if = on ? `LAMP_GREEN : `LAMP_OFF;
        end
    endfunction

    // register select, shared by the write strobes
    function reg_hit;
        input [7:0] addr;
        input [7:0] offset;
        begin
            reg_hit = (addr == offset);
        end
    endfunction

    // supply fault wins over oscillators when several appear together
    assign new_code  = supply_fault              ? `FAULT_SUPPLY :
                       !receive_oscillator_lock  ? `FAULT_RX_OSC :
                       !transmit_oscillator_lock ? `FAULT_TX_OSC : `FAULT_NONE;
    assign any_fault = supply_fault | !receive_oscillator_lock
                       | !transmit_oscillator_lock | hardware_fault;
    assign in_error  = (state != ST_NORMAL);
    // upper address bits are not decoded, so the map repeats every 256 bytes
    assign addr_ok   = (haddr[7:0] <= `REG_FAULT) && (haddr[1:0] == 2'b00);

    // green pattern of the latched fault, one decode for all four lamps
    assign pattern   = fault_pattern(fault_code);

    // error display alternates red and green phases until reset
    always @* begin
        next_state = state;
        case (state)
            ST_NORMAL: begin
                if (any_fault) begin
                    next_state = ST_RED; // RULE3
                end
            end
            ST_RED: begin
                if (phase_cnt == PHASE_CYCLES - 1) begin
                    next_state = ST_GREEN;
                end
            end
            ST_GREEN: begin
                if (phase_cnt == PHASE_CYCLES - 1) begin
                    next_state = ST_RED; // RULE15
                end
            end
            default: begin
                next_state = ST_NORMAL;
            end
        endcase
    end

    always @(posedge ref_clk) begin
        if (rst) begin
            state      <= ST_NORMAL;
            phase_cnt  <= 32'h0000_0000;
            fault_code <= `FAULT_NONE;
        end else begin
            state <= next_state;
            if (state == ST_NORMAL || phase_cnt == PHASE_CYCLES - 1) begin
                phase_cnt <= 32'h0000_0000;
            end else begin
                phase_cnt <= phase_cnt + 32'h0000_0001; // RULE14
            end
            // code frozen at entry, so a fault that clears still reads back
            if (state == ST_NORMAL && any_fault) begin
                fault_code <= new_code;
            end
        end
    end

    // data flow flash timers: a, b inputs (red) and outputs (green)
    assign flash_req = {port_b_out, port_b_in, port_a_out, port_a_in};

    genvar g;
    generate
        for (g = 0; g < 4; g = g + 1) begin : flash_gen
            reg [31:0] cnt;
            // a new pulse restarts the count, so steady traffic stays lit
            always @(posedge ref_clk) begin
                if (rst) begin
                    cnt <= 32'h0000_0000;
                end else if (flash_req[g]) begin
                    cnt <= FLASH_CYCLES; // RULE12 RULE13 RULE14
                end else if (cnt != 32'h0000_0000) begin
                    cnt <= cnt - 32'h0000_0001;
                end
            end

            assign flash_on[g] = (cnt != 32'h0000_0000);
        end
    endgenerate

    // red wins a tie, so overlapping input and output flashes show red
    function [1:0] port_colour;
        input red_on;
        input green_on;
        begin
            port_colour = red_on ? `LAMP_RED : (green_on ? `LAMP_GREEN : `LAMP_OFF);
        end
    endfunction

    // errors while unlocked are ignored: the lamp is already red (carrier) or off (no carrier) there
    always @(posedge ref_clk) begin
        if (rst) begin
            flicker_cnt <= 32'h0000_0000;
        end else if (sync_error && sync_locked) begin
            flicker_cnt <= FLICKER_CYCLES; // RULE11
        end else if (flicker_cnt != 32'h0000_0000) begin
            flicker_cnt <= flicker_cnt - 32'h0000_0001;
        end
    end

    // lamp outputs
    always @(posedge ref_clk) begin
        if (rst) begin
            power_lamp  <= `LAMP_OFF;
            sync_lamp   <= `LAMP_OFF;
            port_a_lamp <= `LAMP_OFF;
            port_b_lamp <= `LAMP_OFF;
        end else if (state == ST_RED) begin
            power_lamp  <= `LAMP_RED; // RULE3
            sync_lamp   <= `LAMP_RED;
            port_a_lamp <= `LAMP_RED;
            port_b_lamp <= `LAMP_RED;
        end else if (state == ST_GREEN) begin
            port_a_lamp <= green_if(pattern[3]); // RULE3
            port_b_lamp <= green_if(pattern[2]);
            sync_lamp   <= green_if(pattern[1]);
            power_lamp  <= green_if(pattern[0]);
        end else if (lamp_test) begin
            power_lamp  <= `LAMP_GREEN;
            sync_lamp   <= `LAMP_GREEN;
            port_a_lamp <= `LAMP_GREEN;
            port_b_lamp <= `LAMP_GREEN;
        end else begin
            power_lamp <= tx_active ? `LAMP_RED : `LAMP_GREEN; // RULE1 RULE2
            if (!carrier_detect) begin
                sync_lamp <= `LAMP_OFF; // RULE8
            end else if (!sync_locked || flicker_cnt != 32'h0000_0000) begin
                sync_lamp <= `LAMP_RED; // RULE9 RULE11
            end else begin
                sync_lamp <= `LAMP_GREEN; // RULE10
            end
            port_a_lamp <= port_colour(flash_on[0], flash_on[1]);
            port_b_lamp <= port_colour(flash_on[2], flash_on[3]);
        end
    end

    // ahb-lite slave, zero wait states, always okay
    always @(posedge ref_clk) begin
        if (rst) begin
            wr_pend   <= 1'b0;
            rd_pend   <= 1'b0;
            addr_q    <= 8'h00;
            hrdata    <= 32'h0000_0000;
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
        end else begin
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
            wr_pend   <= 1'b0;
            rd_pend   <= 1'b0;
            if (hready && hsel && htrans == `HTRANS_NONSEQ) begin
                wr_pend <= hwrite;
                rd_pend <= !hwrite;
                addr_q  <= haddr[7:0];
                hrdata  <= 32'h0000_0000;
                if (!hwrite && addr_ok) begin
                    case (haddr[7:0])
                        `REG_STATUS:  hrdata <= {{(32-`EV_COUNT){1'b0}}, status};
                        `REG_MASK:    hrdata <= {{(32-`EV_COUNT){1'b0}}, mask};
                        `REG_CONTROL: hrdata <= {31'h0000_0000, lamp_test};
                        `REG_LAMPS:   hrdata <= {24'h00_0000, port_a_lamp, port_b_lamp,
                                                 sync_lamp, power_lamp};
                        `REG_FAULT:   hrdata <= {29'h0000_0000, in_error, fault_code};
                        default:      hrdata <= 32'h0000_0000;
                    endcase
                end
            end
        end
    end

    // write strobes for the data phase of an accepted write
    assign wr_mask    = wr_pend && reg_hit(addr_q, `REG_MASK);
    assign wr_control = wr_pend && reg_hit(addr_q, `REG_CONTROL);
    assign wr_status  = wr_pend && reg_hit(addr_q, `REG_STATUS);

    // events, in the bit order of the status register
    assign ev_set = {tx_active & !tx_prev,
                     sync_error & sync_locked,
                     next_state == ST_RED && state == ST_NORMAL};
    assign ev_clr = wr_status ? hwdata[`EV_COUNT-1:0] : {`EV_COUNT{1'b0}};

    // mask and lamp test
    always @(posedge ref_clk) begin
        if (rst) begin
            mask      <= {`EV_COUNT{1'b0}};
            lamp_test <= 1'b0;
        end else begin
            if (wr_mask) begin
                mask <= hwdata[`EV_COUNT-1:0];
            end
            if (wr_control) begin
                lamp_test <= hwdata[`CTRL_LAMP_TEST];
            end
        end
    end

    // a new event wins over a write-one clear in the same cycle
    always @(posedge ref_clk) begin
        if (rst) begin
            status  <= {`EV_COUNT{1'b0}};
            tx_prev <= 1'b0;
        end else begin
            tx_prev <= tx_active;
            status  <= (status & ~ev_clr) | ev_set;
        end
    end

    // one cycle behind status, so the pin comes straight from a flop
    always @(posedge ref_clk) begin
        if (rst) begin
            irq <= 1'b0;
        end else begin
            irq <= |(status & mask);
        end
    end

endmodule // status_lamp_encoder
`default_nettype wire

// [core/lamp_consts.vh]
`ifndef LAMP_CONSTS_VH
`define LAMP_CONSTS_VH

// register byte offsets
`define REG_STATUS        8'h00
`define REG_MASK          8'h04
`define REG_CONTROL       8'h08
`define REG_LAMPS         8'h0c
`define REG_FAULT         8'h10

// status / mask bit positions
`define EV_FAULT          0
`define EV_SYNC_LOSS      1
`define EV_TX_START       2
`define EV_COUNT          3

// control register fields
`define CTRL_LAMP_TEST    0
`define CTRL_RESET_VAL    32'h0000_0000

// lamp colour codes: {red, green}
`define LAMP_OFF          2'b00
`define LAMP_GREEN        2'b01
`define LAMP_RED          2'b10

// fault codes
`define FAULT_NONE        2'h0
`define FAULT_SUPPLY      2'h1
`define FAULT_RX_OSC      2'h2
`define FAULT_TX_OSC      2'h3

// timing: times in ms, clock in kHz, counts derived
`define CLK_KHZ           100000
`define FLASH_MS          50
`define FLICKER_MS        30
`define PHASE_MS          500
`define FLASH_CYCLES      (`FLASH_MS * `CLK_KHZ)
`define FLICKER_CYCLES    (`FLICKER_MS * `CLK_KHZ)
`define PHASE_CYCLES      (`PHASE_MS * `CLK_KHZ)

// ahb-lite encodings
`define HTRANS_NONSEQ     2'b10
`define HSIZE_WORD        3'b010

`endif

// [tb/lamp_panel.sv]
`timescale 1ns/1ps
`default_nettype none
module lamp_panel (
    // lamps
    input  wire logic [1:0] power_lamp, sync_lamp, port_a_lamp, port_b_lamp,
    // what the operator sees, {a,b,sync,pwr}
    output logic      [3:0] green_seen,
    output logic      [3:0] red_seen
);
    // both halves lit would look orange, so each colour is seen on its own
    assign green_seen = {port_a_lamp[0], port_b_lamp[0], sync_lamp[0], power_lamp[0]};
    assign red_seen   = {port_a_lamp[1], port_b_lamp[1], sync_lamp[1], power_lamp[1]};
endmodule // lamp_panel
`default_nettype wire

// [tb/lamp_checker_asserts.sv]
`timescale 1ns/1ps
`default_nettype none
`include "lamp_consts.vh"
module lamp_checker #(
    parameter FLASH_CYCLES   = 4,
    parameter FLICKER_CYCLES = 3,
    parameter PHASE_CYCLES   = 8
) (
    // clock, reset and conditions
    input wire logic       ref_clk, rst, tx_active, carrier_detect, sync_locked, sync_error,
    input wire logic       port_b_in, port_b_out, supply_fault, hardware_fault,
    input wire logic       receive_oscillator_lock, transmit_oscillator_lock,
    // lamps
    input wire logic [1:0] power_lamp, sync_lamp, port_a_lamp, port_b_lamp
);
    localparam int PH = PHASE_CYCLES;
    logic        fault, err, ok;
    logic [31:0] flk, redb;
    assign fault = supply_fault | hardware_fault | !receive_oscillator_lock
                   | !transmit_oscillator_lock;
    assign ok = !err && !fault;
    // one spare cycle on each count so a flash ending late is never misjudged
    always @(posedge ref_clk) begin
        if (rst) begin
            err <= 1'b0;
            flk <= '0;
            redb <= '0;
        end else begin
            err <= err | fault;
            flk <= (sync_error && sync_locked) ? FLICKER_CYCLES + 1 : (flk != 0 ? flk - 1 : 0);
            redb <= port_b_in ? FLASH_CYCLES + 1 : (redb != 0 ? redb - 1 : 0);
        end
    end
    default clocking @(posedge ref_clk); endclocking
    default disable iff (rst);
    property p_idle; ok && !tx_active |=> power_lamp == `LAMP_GREEN; endproperty
    a_idle: assert property (p_idle) else $error("power lamp not green");
    property p_tx; ok && tx_active |=> power_lamp == `LAMP_RED; endproperty
    a_tx: assert property (p_tx) else $error("power lamp not red");
    property p_off; ok && flk == 0 && !carrier_detect |=> sync_lamp == `LAMP_OFF; endproperty
    a_off: assert property (p_off) else $error("sync lamp not off");
    property p_carr;
        ok && flk == 0 && carrier_detect && !sync_locked |=> sync_lamp == `LAMP_RED;
    endproperty
    a_carr: assert property (p_carr) else $error("sync lamp not red");
    property p_lock;
        ok && flk == 0 && carrier_detect && sync_locked && !sync_error
        |=> sync_lamp == `LAMP_GREEN;
    endproperty
    a_lock: assert property (p_lock) else $error("sync lamp not green");
    property p_flick;
        ok && carrier_detect && sync_locked && sync_error ##1 (ok && carrier_detect)[*2]
        |-> (sync_lamp == `LAMP_RED)[*2];
    endproperty
    a_flick: assert property (p_flick) else $error("no red flicker");
    property p_bin; ok && port_b_in ##1 ok |=> port_b_lamp == `LAMP_RED; endproperty
    a_bin: assert property (p_bin) else $error("port b not red");
    property p_bout;
        ok && port_b_out && !port_b_in ##1 ok && redb == 0 |=> port_b_lamp == `LAMP_GREEN;
    endproperty
    a_bout: assert property (p_bout) else $error("port b not green");
    property p_supply;
        !err && supply_fault |-> ##2 {port_a_lamp, port_b_lamp, sync_lamp, power_lamp} == 8'haa
        ##PH {port_a_lamp, port_b_lamp, sync_lamp, power_lamp} == 8'h01;
    endproperty
    a_supply: assert property (p_supply) else $error("supply pattern wrong");
endmodule // lamp_checker
bind status_lamp_encoder lamp_checker #(.FLASH_CYCLES(FLASH_CYCLES),
    .FLICKER_CYCLES(FLICKER_CYCLES), .PHASE_CYCLES(PHASE_CYCLES)) chk (.*);
`default_nettype wire

// [tb/status_lamp_encoder_tb_top.sv]
`timescale 1ns/1ps
`default_nettype none
`include "lamp_consts.vh"
`define LMP {port_a_lamp, port_b_lamp, sync_lamp, power_lamp}
`define CHK(n, e, a) begin checks++; if ((a) !== (e)) begin num_errors++; \
    $display("[FAIL] %s exp %h got %h", n, e, a); end end
module status_lamp_encoder_tb_top;
    logic        ref_clk, rst, tx_active, carrier_detect, sync_locked, sync_error;
    logic        port_a_in, port_a_out, port_b_in, port_b_out, supply_fault;
    logic        receive_oscillator_lock, transmit_oscillator_lock, hardware_fault;
    logic        hsel, hwrite, hready, hreadyout, hresp, irq;
    logic [1:0]  power_lamp, sync_lamp, port_a_lamp, port_b_lamp, htrans;
    logic [2:0]  hsize;
    logic [31:0] haddr, hwdata, hrdata, rd;
    logic [3:0]  green_seen, red_seen;
    int          num_errors = 0;
    int          checks = 0;
    assign hready = hreadyout;
    status_lamp_encoder #(.FLASH_CYCLES(4), .FLICKER_CYCLES(3), .PHASE_CYCLES(8)) uut (.*);
    lamp_panel panel (.*);
    initial begin
        ref_clk = 1'b0;
        forever #5 ref_clk = ~ref_clk;
    end
    task automatic summarize;
        $display("checks %0d mismatches %0d", checks, num_errors);
        if (num_errors == 0 && checks > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge ref_clk);
    endtask
    task automatic wrdy;
        int i;
        i = 0;
        do begin @(posedge ref_clk); i++; end while (hready !== 1'b1 && i < 20);
        if (i >= 20) begin num_errors++; summarize; end
    endtask
    task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] d);
        hsel <= 1'b1; htrans <= `HTRANS_NONSEQ; haddr <= a; hwrite <= w;
        wrdy;
        hsel <= 1'b0; htrans <= 2'h0; hwdata <= d;
        wrdy;
        rd = hrdata;
    endtask
    task automatic reset_dut;
        rst <= 1'b1; tx_active <= 0; carrier_detect <= 0; sync_locked <= 0; sync_error <= 0;
        port_a_in <= 0; port_a_out <= 0; port_b_in <= 0; port_b_out <= 0; supply_fault <= 0;
        receive_oscillator_lock <= 1; transmit_oscillator_lock <= 1; hardware_fault <= 0;
        hsel <= 0; htrans <= 2'h0; haddr <= 0; hwrite <= 0; hsize <= `HSIZE_WORD; hwdata <= 0;
        cyc(5);
        rst <= 1'b0;
        cyc(1);
    endtask
    task automatic t_normal;
        reset_dut; cyc(1);
        `CHK("idle", 8'h01, `LMP)
        tx_active <= 1; cyc(2); `CHK("tx", 8'h02, `LMP)
        tx_active <= 0; carrier_detect <= 1; cyc(2); `CHK("carrier", 8'h09, `LMP)
        sync_locked <= 1; cyc(2); `CHK("locked", 8'h05, `LMP)
        sync_error <= 1; cyc(1); sync_error <= 0; cyc(2); `CHK("flick", 8'h09, `LMP)
        cyc(5); `CHK("flick end", 8'h05, `LMP)
        carrier_detect <= 0; sync_locked <= 0; cyc(2); `CHK("no sig", 8'h01, `LMP)
        $display("t_normal done");
    endtask
    task automatic t_ports;
        reset_dut;
        port_a_in <= 1; cyc(1); port_a_in <= 0; cyc(2); `CHK("a in", 8'h81, `LMP)
        cyc(6); port_a_out <= 1; cyc(1); port_a_out <= 0; cyc(2);
        `CHK("a out", 8'h41, `LMP)
        cyc(6); `CHK("a flash end", 8'h01, `LMP)
        port_b_in <= 1; port_b_out <= 1; cyc(1); port_b_in <= 0; port_b_out <= 0; cyc(2);
        `CHK("b both", 8'h21, `LMP)
        cyc(6); port_b_out <= 1; cyc(1); port_b_out <= 0; cyc(2);
        `CHK("b out", 8'h11, `LMP)
        $display("t_ports done");
    endtask
    task automatic t_irq;
        reset_dut;
        bus(0, 32'(`REG_MASK), 0); `CHK("mask rst", 32'h0, rd)
        bus(1, 32'(`REG_MASK), 32'h2);
        carrier_detect <= 1; sync_locked <= 1; sync_error <= 1; cyc(1); sync_error <= 0; cyc(3);
        `CHK("irq set", 1'b1, irq)
        bus(0, 32'(`REG_STATUS), 0); `CHK("status", 32'h2, rd)
        bus(1, 32'(`REG_STATUS), 32'h2); cyc(2); `CHK("irq clr", 1'b0, irq)
        bus(0, 32'h40, 0); `CHK("unmapped", 32'h0, rd)
        $display("t_irq done");
    endtask
    task automatic t_fault(input int k, input logic [3:0] g);
        reset_dut;
        case (k)
            0: supply_fault <= 1;
            1: receive_oscillator_lock <= 0;
            2: transmit_oscillator_lock <= 0;
            default: hardware_fault <= 1;
        endcase
        cyc(3); `CHK("all red", 4'hf, red_seen)
        supply_fault <= 0; receive_oscillator_lock <= 1; transmit_oscillator_lock <= 1;
        hardware_fault <= 0; tx_active <= 1; carrier_detect <= 1;
        cyc(8); `CHK("pattern", g, green_seen)
        `CHK("no red", 4'h0, red_seen)
        cyc(8); `CHK("repeat", 4'hf, red_seen)
        bus(0, 32'(`REG_FAULT), 0); `CHK("in error", 1'b1, rd[2])
        $display("t_fault %0d done", k);
    endtask
    initial begin
        t_normal;
        t_ports;
        t_irq;
        t_fault(0, 4'b0001);
        t_fault(1, 4'b1010);
        t_fault(2, 4'b1001);
        t_fault(3, 4'b1111);
        summarize;
    end
endmodule // status_lamp_encoder_tb_top
`default_nettype wire
